/* File: core/wdr_pkg.sv */
// constants, types and helpers shared by the watchdog and reset block
// assumes a single 250 MHz core clock and an axi4-lite register bus
package wdr_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] WDR_CTRL_OFS = 8'hd8;
	localparam logic [7:0] WDR_STAT_OFS = 8'he0;
	localparam logic [7:0] WDR_CTRL_RST = 8'hfe;
	localparam int WDR_C_BIT = 0;
	localparam int WDR_SR_BIT = 1;
	localparam int WDR_CNT_LSB = 2;
	localparam int WDR_ST_WAIT_BIT = 0;
	localparam int WDR_ST_STOP_BIT = 1;
	localparam int WDR_ST_ACT_BIT = 2;
	localparam int WDR_ST_NMI_BIT = 3;
	localparam int WDR_ST_CAUSE_BIT = 4;
	localparam logic [1:0] WDR_RESP_OKAY = 2'h0;
	localparam logic [1:0] WDR_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// timing, in core clock cycles
	// ------------------------------------------------------------------
	localparam int WDR_DIV_CYC = 12;
	localparam int WDR_PRE_CYC = 256;
	localparam int WDR_STEP_CYC = WDR_DIV_CYC * WDR_PRE_CYC;
	localparam int WDR_NUM_PERIODS = 64;
	localparam int WDR_MAX_PERIOD = WDR_STEP_CYC * WDR_NUM_PERIODS;
	localparam int WDR_STAB_CYC = 2048;
	localparam logic [6:0] WDR_CNT_RST = 7'h7f;
	localparam logic [6:0] WDR_CNT_FALL = 7'h40;
	localparam logic [11:0] WDR_RST_VEC = 12'hffe;

	typedef enum logic [1:0] {
		WDR_PM_RUN = 2'b00,
		WDR_PM_WAIT = 2'b01,
		WDR_PM_STOP = 2'b10
	} wdr_pm_e;

	// register field order is mirrored against the physical counter
	function automatic logic [5:0] wdr_rev6(input logic [5:0] v);
		logic [5:0] r;
		r = '0;
		for (int i = 0; i < 6; i++) begin
			r[i] = v[5 - i];
		end
		return r;
	endfunction : wdr_rev6

endpackage : wdr_pkg

/* File: core/wdr_stab.sv */
// reset stabilisation stretcher
// assumes trig is synchronous to clk; output is held for STAB cycles after trig drops
module wdr_stab import wdr_pkg::*; #(
	parameter int STAB = WDR_STAB_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic trig,
	output logic rst_out
);

	logic [11:0] cnt_r;
	logic act_r;

	// ------------------------------------------------------------------
	// delay counter
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= '0;
			act_r <= 1'b1;
		end else if (trig) begin
			cnt_r <= '0;
			act_r <= 1'b1;
		end else if (act_r) begin
			if (cnt_r == 12'(STAB - 1)) begin
				act_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r + 12'h001;
			end
		end
	end

	assign rst_out = act_r;

	stab_count_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(act_r) |-> $past(cnt_r) == 12'(STAB - 1) && !$past(trig))
		else $error("reset released before stabilisation count completed");

endmodule : wdr_stab

/* File: core/wdr_top.sv */
// digital watchdog with its reset generation and core reset hand-off
// assumes axi4-lite master on clk; pin inputs are asynchronous and synchronised here
// activation and stop-control options are build-time parameters

// Behaviour
// - watchdog timeout with watchdog active raises the internal chip reset
// - the internal chip reset returns the watchdog counter to its reset state
// - every reset source passes through the same stabilisation delay
// - internal reset releases 2048 cycles after the triggering condition ends
// - on reset the return stack is cleared and pc loads vector 0ffe
// - after reset the core runs in non-maskable interrupt mode
// - return from interrupt services a pending interrupt, else continues
// - register resets to 0fe (0ff with hardware option): activation per option, count and soft reset bits set
// - software option: inactive until software writes activation bit to one
// - once active, only a device reset deactivates the watchdog
// - inactive watchdog lets a stop instruction enter stop mode
// - hardware option: watchdog active from reset onward
// - hardware option without stop control: stop acts as wait, counting on
// - stop control, nmi pin low: stop acts as wait, counting on
// - hardware option with stop control, nmi pin high: counter frozen, core enters stop
// - leaving stop on an interrupt resumes counting from the held value
// - soft reset bit falling from one to zero resets the device
// - register bit 7 is counter lsb, register bit 2 its msb
// - reset fires when counter bit 6 falls to zero
// - 64 periods from 3072 to 196608 cycles in 3072-cycle steps
// - count clock is the internal clock divided by twelve
module wdr_top import wdr_pkg::*; #(
	parameter bit HW_ACTIVATION = 1'b0,
	parameter bit EXT_STOP = 1'b0,
	parameter int STAB = WDR_STAB_CYC,
	parameter int PRE = WDR_PRE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rst_pin_n,
	input wire logic nmi_pin,
	input wire logic stop_exec,
	input wire logic wake_irq,
	input wire logic return_from_interrupt_exec,
	input wire logic irq_pending,
	output logic chip_rst,
	output logic pc_load,
	output logic [11:0] pc_vector,
	output logic stack_clear,
	output logic nmi_mode,
	output logic return_from_interrupt_take_irq,
	output logic stop_mode,
	output logic wait_mode,
	output logic wd_active,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic pin_meta_r, pin_sync_r, nmi_meta_r, nmi_sync_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
			nmi_meta_r <= 1'b0;
			nmi_sync_r <= 1'b0;
		end else begin
			pin_meta_r <= rst_pin_n;
			pin_sync_r <= pin_meta_r;
			nmi_meta_r <= nmi_pin;
			nmi_sync_r <= nmi_meta_r;
		end
	end

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [6:0] cnt_r;
	logic ctrl_c_r;
	logic [3:0] div_r;
	logic [7:0] pre_r;
	logic step;
	logic timeout;
	logic soft_trig;
	logic trig_r;
	logic cause_r;
	logic nmi_mode_r;
	wdr_pm_e pm_r;
	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic do_write;
	logic ctrl_wr;
	logic stat_wr;
	logic [7:0] ctrl_rd;
	logic [7:0] stat_rd;

	// ------------------------------------------------------------------
	// reset generation
	// ------------------------------------------------------------------
	// all sources share one registered trigger so they see the same delay
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trig_r <= 1'b0;
		end else begin
			trig_r <= timeout || soft_trig || !pin_sync_r;
		end
	end

	wdr_stab #(.STAB(STAB)) u_stab (
		.clk(clk),
		.sys_rst(sys_rst),
		.trig(trig_r),
		.rst_out(chip_rst)
	);

	assign pc_load = chip_rst;
	assign stack_clear = chip_rst;
	assign pc_vector = WDR_RST_VEC;

	// ------------------------------------------------------------------
	// core interrupt mode hand-off
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			nmi_mode_r <= 1'b1;
		end else if (chip_rst) begin
			nmi_mode_r <= 1'b1;
		end else if (return_from_interrupt_exec) begin
			nmi_mode_r <= 1'b0;
		end
	end

	assign nmi_mode = nmi_mode_r;
	assign return_from_interrupt_take_irq = return_from_interrupt_exec && irq_pending;

	// ------------------------------------------------------------------
	// count clock
	// ------------------------------------------------------------------
	// the prescaler runs outside stop mode and is not cleared on a reload, so the first step after a reload can be short
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_r <= '0;
			pre_r <= '0;
		end else if (pm_r != WDR_PM_STOP) begin
			if (div_r == 4'(WDR_DIV_CYC - 1)) begin
				div_r <= '0;
				pre_r <= (pre_r == 8'(PRE - 1)) ? 8'h00 : pre_r + 8'h01;
			end else begin
				div_r <= div_r + 4'h1;
			end
		end
	end

	assign step = (div_r == 4'(WDR_DIV_CYC - 1)) && (pre_r == 8'(PRE - 1))
		&& (pm_r != WDR_PM_STOP);
	assign timeout = wd_active && step && (cnt_r == WDR_CNT_FALL) && !chip_rst;

	// ------------------------------------------------------------------
	// downcounter and activation
	// ------------------------------------------------------------------
	assign soft_trig = ctrl_wr && cnt_r[6] && !wdata_r[WDR_SR_BIT] && !chip_rst;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= WDR_CNT_RST;
		end else if (chip_rst) begin
			cnt_r <= WDR_CNT_RST;
		end else if (ctrl_wr) begin
			cnt_r <= {wdata_r[WDR_SR_BIT], wdr_rev6(wdata_r[7:WDR_CNT_LSB])};
		end else if (step) begin
			cnt_r <= cnt_r - 7'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_c_r <= HW_ACTIVATION;
		end else if (chip_rst) begin
			ctrl_c_r <= HW_ACTIVATION;
		end else if (ctrl_wr && wdata_r[WDR_C_BIT]) begin
			ctrl_c_r <= 1'b1;
		end
	end

	assign wd_active = ctrl_c_r;
	assign ctrl_rd = {wdr_rev6(cnt_r[5:0]), cnt_r[6], ctrl_c_r};

	// watchdog-cause flag survives chip reset; set wins over software clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cause_r <= 1'b0;
		end else if (timeout) begin
			cause_r <= 1'b1;
		end else if (stat_wr && wdata_r[WDR_ST_CAUSE_BIT]) begin
			cause_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// power mode
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pm_r <= WDR_PM_RUN;
		end else if (chip_rst) begin
			pm_r <= WDR_PM_RUN;
		end else begin
			unique case (pm_r)
				WDR_PM_RUN: begin
					if (stop_exec) begin
						if (!wd_active) begin
							pm_r <= WDR_PM_STOP;
						end else if (HW_ACTIVATION && EXT_STOP && nmi_sync_r) begin
							pm_r <= WDR_PM_STOP;
						end else begin
							pm_r <= WDR_PM_WAIT;
						end
					end
				end
				WDR_PM_WAIT, WDR_PM_STOP: begin
					if (wake_irq) begin
						pm_r <= WDR_PM_RUN;
					end
				end
				default: begin
					pm_r <= WDR_PM_RUN;
				end
			endcase
		end
	end

	assign stop_mode = (pm_r == WDR_PM_STOP);
	assign wait_mode = (pm_r == WDR_PM_WAIT);
	assign stat_rd = {3'h0, cause_r, nmi_mode_r, wd_active, stop_mode, wait_mode};

	// ------------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------------
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
	assign ctrl_wr = do_write && (awaddr_r == WDR_CTRL_OFS) && wstrb_r[0];
	assign stat_wr = do_write && (awaddr_r == WDR_STAT_OFS) && wstrb_r[0];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= WDR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (awaddr_r == WDR_CTRL_OFS || awaddr_r == WDR_STAT_OFS)
					? WDR_RESP_OKAY : WDR_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_arready = !rvalid_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= WDR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			if (s_axi_araddr == WDR_CTRL_OFS) begin
				rdata_r <= {24'h000000, ctrl_rd};
				rresp_r <= WDR_RESP_OKAY;
			end else if (s_axi_araddr == WDR_STAT_OFS) begin
				rdata_r <= {24'h000000, stat_rd};
				rresp_r <= WDR_RESP_OKAY;
			end else begin
				rdata_r <= '0;
				rresp_r <= WDR_RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	timeout_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
		timeout |-> ##2 chip_rst)
		else $error("timeout did not raise chip reset");

	reset_value_a: assert property (@(posedge clk) disable iff (sys_rst)
		chip_rst |=> ctrl_rd == (HW_ACTIVATION ? 8'hff : WDR_CTRL_RST))
		else $error("control register not at reset value");

	nmi_after_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(chip_rst) |-> nmi_mode_r)
		else $error("core not in nmi mode after reset");

	active_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(wd_active) |-> $past(chip_rst))
		else $error("watchdog deactivated without reset");

	hw_always_a: assert property (@(posedge clk) disable iff (sys_rst)
		HW_ACTIVATION |-> wd_active)
		else $error("hardware watchdog inactive");

	stop_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
		stop_mode && $past(stop_mode) && !$past(ctrl_wr) && !$past(chip_rst)
		|-> $stable(cnt_r))
		else $error("counter moved in stop mode");

	soft_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_wr && cnt_r[6] && !wdata_r[WDR_SR_BIT] && !chip_rst |-> ##2 chip_rst)
		else $error("soft reset bit clear did not reset");

	count_load_a: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_wr && !chip_rst |=> ctrl_rd[7:1] == $past(wdata_r[7:1]))
		else $error("count write not loaded");

	idle_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
		pm_r == WDR_PM_RUN && stop_exec && !wd_active && !chip_rst |=> stop_mode)
		else $error("stop refused while watchdog inactive");

endmodule : wdr_top

/* File: tb/wdr_testbench.sv */
// self-checking bench for the watchdog and reset block
// assumes two wdr_top builds on shared pins and bus, shortened stretch and prescaler counts:
// software activation, and hardware activation with external stop control
module testbench import wdr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam int STAB_T = 8;
	localparam int PRE_T = 8;
	localparam int STEP = WDR_DIV_CYC * PRE_T;
	localparam int LIMIT = 4000;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rst_pin_n = 1'b1;
	logic nmi_pin = 1'b0;
	logic stop_exec = 1'b0;
	logic wake_irq = 1'b0;
	logic return_from_interrupt_exec = 1'b0;
	logic irq_pending = 1'b0;
	logic chip_rst, pc_load, stack_clear, nmi_mode, return_from_interrupt_take_irq, stop_mode, wait_mode, wd_active;
	logic [11:0] pc_vector;
	logic chip_rst_hw, stop_hw, wait_hw, wd_active_hw;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int n, t0;

	always #2 clk = ~clk;

	wdr_top #(.HW_ACTIVATION(1'b0), .EXT_STOP(1'b0), .STAB(STAB_T), .PRE(PRE_T)) dut (
		.clk(clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .nmi_pin(nmi_pin),
		.stop_exec(stop_exec), .wake_irq(wake_irq), .return_from_interrupt_exec(return_from_interrupt_exec),
		.irq_pending(irq_pending), .chip_rst(chip_rst), .pc_load(pc_load),
		.pc_vector(pc_vector), .stack_clear(stack_clear), .nmi_mode(nmi_mode),
		.return_from_interrupt_take_irq(return_from_interrupt_take_irq), .stop_mode(stop_mode), .wait_mode(wait_mode),
		.wd_active(wd_active), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	// second build sees every write too; its handshakes and response codes match the first, its read data can differ, and none are read
	wdr_top #(.HW_ACTIVATION(1'b1), .EXT_STOP(1'b1), .STAB(STAB_T), .PRE(PRE_T)) dut_hw (
		.clk(clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .nmi_pin(nmi_pin),
		.stop_exec(stop_exec), .wake_irq(wake_irq), .return_from_interrupt_exec(return_from_interrupt_exec),
		.irq_pending(irq_pending), .chip_rst(chip_rst_hw), .pc_load(),
		.pc_vector(), .stack_clear(), .nmi_mode(), .return_from_interrupt_take_irq(),
		.stop_mode(stop_hw), .wait_mode(wait_hw), .wd_active(wd_active_hw),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
		.s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready)
	);

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task test_done;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	// hang guard: a lost handshake or a reset that never comes ends the run here
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			test_done();
		end
	end

	task wr(input logic [7:0] a, input logic [7:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge clk);
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : wr

	task rdr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge clk);
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rdr

	// count field read back as a counter value; one step of slack for the prescaler phase
	task cnt_chk(input logic [6:0] c);
		logic [6:0] s;
		s = {rd[1], rd[2], rd[3], rd[4], rd[5], rd[6], rd[7]};
		check(32'(s == c || s == c - 7'h1), 32'h1);
	endtask : cnt_chk

	task rise(output int k);
		k = 0;
		while (chip_rst !== 1'b1) begin
			@(posedge clk);
			k++;
		end
	endtask : rise

	task high(output int k);
		k = 0;
		while (chip_rst === 1'b1) begin
			@(posedge clk);
			k++;
		end
	endtask : high

	task fin(input string s);
		$display("test %s done", s);
	endtask : fin

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		check(32'(chip_rst & pc_load & stack_clear & nmi_mode), 32'h1);
		check({20'h0, pc_vector}, 32'h00000ffe);
		high(n);
		check(32'(n >= STAB_T && n <= STAB_T + 6), 32'h1);
		rdr(WDR_CTRL_OFS);
		check(rd, 32'h000000fe);
		rdr(8'h04);
		check({30'h0, rs}, {30'h0, WDR_RESP_SLVERR});
		check(rd, 32'h0);
		wr(8'h04, 8'h00);
		check({30'h0, rs}, {30'h0, WDR_RESP_SLVERR});
		rdr(WDR_STAT_OFS);
		check({28'h0, rd[3:0]}, 32'h8);
		fin("reset");
		@(posedge clk);
		return_from_interrupt_exec <= 1'b1;
		irq_pending <= 1'b1;
		@(posedge clk);
		return_from_interrupt_exec <= 1'b0;
		check(32'(return_from_interrupt_take_irq), 32'h1);
		@(posedge clk);
		check(32'(nmi_mode), 32'h0);
		irq_pending <= 1'b0;
		return_from_interrupt_exec <= 1'b1;
		@(posedge clk);
		return_from_interrupt_exec <= 1'b0;
		check(32'(return_from_interrupt_take_irq), 32'h0);
		fin("return_from_interrupt");
		wr(WDR_CTRL_OFS, 8'h06);
		check({30'h0, rs}, {30'h0, WDR_RESP_OKAY});
		@(posedge clk);
		stop_exec <= 1'b1;
		@(posedge clk);
		stop_exec <= 1'b0;
		@(posedge clk);
		check(32'({stop_mode, wait_mode}), 32'h2);
		repeat (4 * STEP) @(posedge clk);
		wake_irq <= 1'b1;
		@(posedge clk);
		wake_irq <= 1'b0;
		@(posedge clk);
		check(32'(stop_mode), 32'h0);
		rdr(WDR_CTRL_OFS);
		cnt_chk(7'h60);
		check(32'(rd[0]), 32'h0);
		fin("stop");
		wr(WDR_CTRL_OFS, 8'h83);
		check(32'(wd_active), 32'h1);
		rdr(WDR_STAT_OFS);
		check(32'(rd[2]), 32'h1);
		// a write with the activation bit low must not switch the watchdog off
		wr(WDR_CTRL_OFS, 8'h82);
		t0 = cyc;
		rdr(WDR_CTRL_OFS);
		check(32'(rd[0]), 32'h1);
		cnt_chk(7'h41);
		@(posedge clk);
		stop_exec <= 1'b1;
		@(posedge clk);
		stop_exec <= 1'b0;
		@(posedge clk);
		check(32'({stop_mode, wait_mode}), 32'h1);
		rise(n);
		check(32'(cyc - t0 >= STEP - 4 && cyc - t0 <= 2 * STEP + 6), 32'h1);
		check(32'(pc_load & stack_clear), 32'h1);
		high(n);
		check(32'(n >= STAB_T && n <= STAB_T + 6), 32'h1);
		rdr(WDR_CTRL_OFS);
		check(rd, 32'h000000fe);
		check(32'(wd_active), 32'h0);
		rdr(WDR_STAT_OFS);
		check(32'(rd[4]), 32'h1);
		// cause flag is write-one-to-clear
		wr(WDR_STAT_OFS, 8'h10);
		rdr(WDR_STAT_OFS);
		check(32'(rd[4]), 32'h0);
		fin("timeout");
		wr(WDR_CTRL_OFS, 8'hfc);
		rise(n);
		check(32'(n <= 4), 32'h1);
		high(n);
		check(32'(n >= STAB_T && n <= STAB_T + 6), 32'h1);
		check(32'(nmi_mode), 32'h1);
		fin("soft");
		@(posedge clk);
		rst_pin_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_pin_n <= 1'b1;
		rise(n);
		check(32'(n <= 6), 32'h1);
		high(n);
		check(32'(n >= STAB_T && n <= STAB_T + 10), 32'h1);
		fin("pin");
		check(32'(wd_active_hw), 32'h1);
		@(posedge clk);
		stop_exec <= 1'b1;
		@(posedge clk);
		stop_exec <= 1'b0;
		@(posedge clk);
		check(32'({stop_hw, wait_hw}), 32'h1);
		check(32'({stop_mode, wait_mode}), 32'h2);
		wake_irq <= 1'b1;
		nmi_pin <= 1'b1;
		@(posedge clk);
		wake_irq <= 1'b0;
		// short period loaded, then frozen in stop for longer than it lasts
		wr(WDR_CTRL_OFS, 8'h82);
		stop_exec <= 1'b1;
		@(posedge clk);
		stop_exec <= 1'b0;
		@(posedge clk);
		check(32'({stop_hw, wait_hw}), 32'h2);
		repeat (3 * STEP) @(posedge clk);
		check(32'({chip_rst_hw, stop_hw}), 32'h1);
		wake_irq <= 1'b1;
		@(posedge clk);
		wake_irq <= 1'b0;
		n = 0;
		while (chip_rst_hw !== 1'b1 && n < 3 * STEP) begin
			@(posedge clk);
			n++;
		end
		check(32'(chip_rst_hw), 32'h1);
		fin("hardware option");
		test_done();
	end

endmodule : testbench
